// ### src/brdcb_bank.sv
`timescale 1ns/1ps
module brdcb_bank
	import brdcb_pkg::*;
#(
	parameter int SLEEP_CYC_P0 = SLEEP_CYC_0,
	parameter int SLEEP_CYC_P1 = SLEEP_CYC_1,
	parameter int SLEEP_CYC_P2 = SLEEP_CYC_2,
	parameter int SLEEP_CYC_P3 = SLEEP_CYC_3
) (
	// Clock and reset.
	input wire logic mclk_i,
	input wire logic resetn_i,
	// Register access port.
	input wire logic wr_en_i,
	input wire logic rd_en_i,
	input wire logic [7:0] addr_i,
	input wire logic [7:0] wdata_i,
	output logic [7:0] rdata_o,
	output logic rvalid_o,
	// Activity seen by the sleep timer.
	input wire logic activity_i,
	// Frequency check measurement.
	input wire logic [7:0] freq_err_us_i,
	input wire logic freq_err_valid_i,
	// Decay level for the saturation check.
	input wire logic [3:0] decay_level_i,
	// Configuration and status outputs.
	output logic [2:0] node_address_o,
	output logic [4:0] second_preset_pulse_count_o,
	output logic second_preset_first_only_o,
	output logic drive_limit_on_o,
	output logic [9:0] first_preset_drive_limit_ma_o,
	output logic [9:0] second_preset_drive_limit_ma_o,
	output logic [2:0] lowpass_cutoff_khz_o,
	output logic [4:0] first_preset_record_units_o,
	output logic [4:0] second_preset_record_units_o,
	output logic freq_check_on_o,
	output logic [3:0] freq_check_window_len_o,
	output logic [10:0] freq_check_start_us_o,
	output logic freq_check_error_o,
	output logic saturation_hit_o,
	output logic first_preset_nonlinear_o,
	output logic second_preset_nonlinear_o,
	output logic [8:0] overvoltage_th_dv_o,
	output logic [3:0] voltage_check_limit_o,
	output logic sleep_o
);
	// -----------------------------------------------------------------
	// State
	// -----------------------------------------------------------------
	typedef struct packed {
		logic [7:0] pulses_node;
		logic [7:0] limit_p1;
		logic [7:0] limit_p2;
		logic [7:0] record;
		logic [7:0] freq_win;
		logic [7:0] sat_freq;
		logic [7:0] volt_sleep;
		logic [7:0] decouple;
		logic [7:0] rdata;
		logic rvalid;
		logic [31:0] idle_cnt;
		logic sleep;
		logic freq_err;
		logic sat_hit;
		logic [2:0] node_address;
		logic [4:0] p2_pulses;
		logic p2_first_only;
		logic limit_on;
		logic [9:0] lim1_ma;
		logic [9:0] lim2_ma;
		logic [2:0] lpf_khz;
		logic [4:0] rec1;
		logic [4:0] rec2;
		logic fc_on;
		logic [3:0] fc_len;
		logic [10:0] fc_start;
		logic nl1;
		logic nl2;
		logic [8:0] ov_th;
		logic [3:0] vlim;
	} brdcb_state_t;

	brdcb_state_t st;
	brdcb_state_t next_st;

	// Read decode shared by the read path.
	function automatic logic [7:0] brdcb_read(input brdcb_state_t s, input logic [7:0] a);
		case (a)
			ADDR_PULSES_NODE: brdcb_read = s.pulses_node;
			ADDR_LIMIT_P1: brdcb_read = s.limit_p1;
			ADDR_LIMIT_P2: brdcb_read = s.limit_p2;
			ADDR_RECORD: brdcb_read = s.record;
			ADDR_FREQ_WIN: brdcb_read = s.freq_win;
			ADDR_SAT_FREQ: brdcb_read = s.sat_freq;
			ADDR_VOLT_SLEEP: brdcb_read = s.volt_sleep;
			ADDR_DECOUPLE: brdcb_read = s.decouple;
			default: brdcb_read = 8'h00;
		endcase
	endfunction : brdcb_read

	// Sleep delay selection in cycles.
	function automatic logic [31:0] brdcb_sleep_cyc(input logic [1:0] code);
		case (code)
			2'b00: brdcb_sleep_cyc = 32'(SLEEP_CYC_P0);
			2'b01: brdcb_sleep_cyc = 32'(SLEEP_CYC_P1);
			2'b10: brdcb_sleep_cyc = 32'(SLEEP_CYC_P2);
			default: brdcb_sleep_cyc = 32'(SLEEP_CYC_P3);
		endcase
	endfunction : brdcb_sleep_cyc

	// Current limit in mA for a six-bit code, shared by both presets.
	function automatic logic [9:0] brdcb_limit_ma(input logic [5:0] code);
		brdcb_limit_ma = 10'(LIMIT_STEP_MA * {4'h0, code}) + LIMIT_BASE_MA;
	endfunction : brdcb_limit_ma

	// -----------------------------------------------------------------
	// Next-state logic
	// -----------------------------------------------------------------
	always_comb begin
		next_st = st;
		// Register writes; reserved bit of the preset-1 limit is dropped.
		if (wr_en_i) begin
			case (addr_i)
				ADDR_PULSES_NODE: next_st.pulses_node = wdata_i;
				ADDR_LIMIT_P1: next_st.limit_p1 = wdata_i & LIMIT_P1_MASK;
				ADDR_LIMIT_P2: next_st.limit_p2 = wdata_i;
				ADDR_RECORD: next_st.record = wdata_i;
				ADDR_FREQ_WIN: next_st.freq_win = wdata_i;
				ADDR_SAT_FREQ: next_st.sat_freq = wdata_i;
				ADDR_VOLT_SLEEP: next_st.volt_sleep = wdata_i;
				ADDR_DECOUPLE: next_st.decouple = wdata_i;
				default: next_st.rvalid = st.rvalid;
			endcase
		end
		// Read data appears one cycle after the strobe.
		next_st.rvalid = rd_en_i;
		next_st.rdata = rd_en_i ? brdcb_read(st, addr_i) : 8'h00;
		// Decoded configuration from current register contents.
		next_st.node_address = st.pulses_node[7:5];
		next_st.p2_pulses = st.pulses_node[4:0];
		next_st.p2_first_only = (st.pulses_node[4:0] == 5'h00);
		next_st.limit_on = ~st.limit_p1[7];
		next_st.lim1_ma = brdcb_limit_ma(st.limit_p1[5:0]);
		next_st.lim2_ma = brdcb_limit_ma(st.limit_p2[5:0]);
		next_st.lpf_khz = {1'b0, st.limit_p2[7:6]} + 3'h1;
		next_st.rec1 = {1'b0, st.record[7:4]} + 5'h01;
		next_st.rec2 = {1'b0, st.record[3:0]} + 5'h01;
		next_st.fc_on = (st.freq_win[7:4] != 4'h0);
		next_st.fc_len = st.freq_win[7:4];
		next_st.fc_start = 11'(FREQ_START_STEP_US) * {7'h00, st.freq_win[3:0]};
		next_st.nl1 = st.sat_freq[0];
		next_st.nl2 = st.volt_sleep[7];
		case (st.volt_sleep[6:5])
			2'b00: next_st.ov_th = OV_TH_0;
			2'b01: next_st.ov_th = OV_TH_1;
			2'b10: next_st.ov_th = OV_TH_2;
			default: next_st.ov_th = OV_TH_3;
		endcase
		next_st.vlim = {1'b0, st.volt_sleep[2:0]} + 4'h1;
		// Frequency error flag, updated on each measurement while enabled.
		if (!next_st.fc_on) begin
			next_st.freq_err = 1'b0;
		end else if (freq_err_valid_i) begin
			next_st.freq_err = freq_err_us_i > {5'h00, st.sat_freq[7:5]} + 8'h01;
		end
		// Saturation comparison against the four-bit level.
		next_st.sat_hit = decay_level_i > st.sat_freq[4:1];
		// Idle timer toward sleep, only when sleep is allowed.
		if (!st.decouple[SLEEP_ALLOW_BIT] || activity_i || wr_en_i || rd_en_i) begin
			next_st.idle_cnt = 32'h0000_0000;
			next_st.sleep = 1'b0;
		end else if (st.idle_cnt >= brdcb_sleep_cyc(st.volt_sleep[4:3]) - 32'h0000_0001) begin
			next_st.sleep = 1'b1;
		end else begin
			next_st.idle_cnt = st.idle_cnt + 32'h0000_0001;
		end
	end

	// -----------------------------------------------------------------
	// State register
	// -----------------------------------------------------------------
	always_ff @(posedge mclk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	// Outputs straight from the state flip-flops.
	assign rdata_o = st.rdata;
	assign rvalid_o = st.rvalid;
	assign node_address_o = st.node_address;
	assign second_preset_pulse_count_o = st.p2_pulses;
	assign second_preset_first_only_o = st.p2_first_only;
	assign drive_limit_on_o = st.limit_on;
	assign first_preset_drive_limit_ma_o = st.lim1_ma;
	assign second_preset_drive_limit_ma_o = st.lim2_ma;
	assign lowpass_cutoff_khz_o = st.lpf_khz;
	assign first_preset_record_units_o = st.rec1;
	assign second_preset_record_units_o = st.rec2;
	assign freq_check_on_o = st.fc_on;
	assign freq_check_window_len_o = st.fc_len;
	assign freq_check_start_us_o = st.fc_start;
	assign freq_check_error_o = st.freq_err;
	assign saturation_hit_o = st.sat_hit;
	assign first_preset_nonlinear_o = st.nl1;
	assign second_preset_nonlinear_o = st.nl2;
	assign overvoltage_th_dv_o = st.ov_th;
	assign voltage_check_limit_o = st.vlim;
	assign sleep_o = st.sleep;

	// -----------------------------------------------------------------
	// Assertions
	// -----------------------------------------------------------------
	// Register write events that the decode checks start from.
	sequence seq_write_p2;
		wr_en_i && addr_i == ADDR_PULSES_NODE;
	endsequence
	sequence seq_write_lim2;
		wr_en_i && addr_i == ADDR_LIMIT_P2;
	endsequence
	sequence seq_write_record;
		wr_en_i && addr_i == ADDR_RECORD;
	endsequence
	sequence seq_write_freq_win;
		wr_en_i && addr_i == ADDR_FREQ_WIN;
	endsequence
	sequence seq_write_volt;
		wr_en_i && addr_i == ADDR_VOLT_SLEEP;
	endsequence

	AST_NODE_ADDR: assert property (@(posedge mclk_i) disable iff (!resetn_i)
		seq_write_p2 ##2 1'b1 |-> node_address_o == $past(wdata_i[7:5], 2))
		else $error("Node address does not follow register write.");
	AST_P2_FIRST: assert property (@(posedge mclk_i) disable iff (!resetn_i)
		seq_write_p2 ##2 1'b1 |-> second_preset_first_only_o == ($past(wdata_i[4:0], 2) == 5'h00))
		else $error("First-only flag wrong for zero pulse count.");
	AST_LIMIT_ON: assert property (@(posedge mclk_i) disable iff (!resetn_i)
		drive_limit_on_o |-> !$past(st.limit_p1[7]))
		else $error("Current limit enabled while disable bit set.");
	AST_LIM1: assert property (@(posedge mclk_i) disable iff (!resetn_i)
		resetn_i |=> first_preset_drive_limit_ma_o
			== LIMIT_STEP_MA * {4'h0, $past(st.limit_p1[5:0])} + LIMIT_BASE_MA)
		else $error("Preset-1 current limit value wrong.");
	AST_RSVD: assert property (@(posedge mclk_i) disable iff (!resetn_i)
		wr_en_i && addr_i == ADDR_LIMIT_P1 |=> st.limit_p1[6] == 1'b0)
		else $error("Reserved bit stored.");
	AST_FC_OFF: assert property (@(posedge mclk_i) disable iff (!resetn_i)
		!freq_check_on_o |-> ##1 !freq_check_error_o || freq_check_on_o)
		else $error("Frequency error set while check disabled.");
	AST_VLIM: assert property (@(posedge mclk_i) disable iff (!resetn_i)
		$past(resetn_i) |-> voltage_check_limit_o != 4'h0 && voltage_check_limit_o <= 4'h8)
		else $error("Voltage check limit out of range.");
	AST_NO_SLEEP: assert property (@(posedge mclk_i) disable iff (!resetn_i)
		!st.decouple[SLEEP_ALLOW_BIT] |=> !sleep_o)
		else $error("Sleep entered while not allowed.");
	AST_READ: assert property (@(posedge mclk_i) disable iff (!resetn_i)
		rd_en_i |=> rvalid_o ##1 (!rvalid_o || $past(rd_en_i)))
		else $error("Read valid timing wrong.");
	AST_P2_COUNT: assert property (@(posedge mclk_i) disable iff (!resetn_i)
		seq_write_p2 ##2 1'b1 |-> second_preset_pulse_count_o == $past(wdata_i[4:0], 2))
		else $error("Preset-2 pulse count does not follow register write.");
	AST_LIM2: assert property (@(posedge mclk_i) disable iff (!resetn_i)
		seq_write_lim2 ##2 1'b1 |-> second_preset_drive_limit_ma_o
			== LIMIT_STEP_MA * {4'h0, $past(wdata_i[5:0], 2)} + LIMIT_BASE_MA)
		else $error("Preset-2 current limit value wrong.");
	AST_LPF: assert property (@(posedge mclk_i) disable iff (!resetn_i)
		seq_write_lim2 ##2 1'b1 |-> lowpass_cutoff_khz_o
			== {1'b0, $past(wdata_i[7:6], 2)} + 3'h1)
		else $error("Lowpass cutoff does not follow its code.");
	AST_REC1: assert property (@(posedge mclk_i) disable iff (!resetn_i)
		seq_write_record ##2 1'b1 |-> first_preset_record_units_o
			== {1'b0, $past(wdata_i[7:4], 2)} + 5'h01)
		else $error("Preset-1 record length wrong.");
	AST_REC2: assert property (@(posedge mclk_i) disable iff (!resetn_i)
		seq_write_record ##2 1'b1 |-> second_preset_record_units_o
			== {1'b0, $past(wdata_i[3:0], 2)} + 5'h01)
		else $error("Preset-2 record length wrong.");
	AST_FC_LEN: assert property (@(posedge mclk_i) disable iff (!resetn_i)
		seq_write_freq_win ##2 1'b1 |-> freq_check_window_len_o == $past(wdata_i[7:4], 2)
			&& freq_check_on_o == ($past(wdata_i[7:4], 2) != 4'h0))
		else $error("Frequency check window or enable wrong.");
	AST_FC_START: assert property (@(posedge mclk_i) disable iff (!resetn_i)
		seq_write_freq_win ##2 1'b1 |-> freq_check_start_us_o
			== 11'(FREQ_START_STEP_US) * {7'h00, $past(wdata_i[3:0], 2)})
		else $error("Frequency check start delay wrong.");
	AST_FC_ERR: assert property (@(posedge mclk_i) disable iff (!resetn_i)
		freq_err_valid_i && st.freq_win[7:4] != 4'h0 |=> freq_check_error_o
			== ($past(freq_err_us_i) > {5'h00, $past(st.sat_freq[7:5])} + 8'h01))
		else $error("Frequency error flag does not match its threshold.");
	AST_SAT: assert property (@(posedge mclk_i) disable iff (!resetn_i)
		resetn_i |=> saturation_hit_o == ($past(decay_level_i) > $past(st.sat_freq[4:1])))
		else $error("Saturation hit does not match its level.");
	AST_NL1: assert property (@(posedge mclk_i) disable iff (!resetn_i)
		resetn_i |=> first_preset_nonlinear_o == $past(st.sat_freq[0]))
		else $error("Preset-1 nonlinear enable wrong.");
	AST_NL2: assert property (@(posedge mclk_i) disable iff (!resetn_i)
		resetn_i |=> second_preset_nonlinear_o == $past(st.volt_sleep[7]))
		else $error("Preset-2 nonlinear enable wrong.");
	AST_OV_TH: assert property (@(posedge mclk_i) disable iff (!resetn_i)
		seq_write_volt ##2 1'b1 |-> overvoltage_th_dv_o == ($past(wdata_i[6], 2)
			? ($past(wdata_i[5], 2) ? OV_TH_3 : OV_TH_2)
			: ($past(wdata_i[5], 2) ? OV_TH_1 : OV_TH_0)))
		else $error("Overvoltage threshold does not follow its code.");
	AST_SLEEP_AT: assert property (@(posedge mclk_i) disable iff (!resetn_i)
		$rose(sleep_o) |-> $past(st.decouple[SLEEP_ALLOW_BIT])
			&& $past(st.idle_cnt) == brdcb_sleep_cyc($past(st.volt_sleep[4:3])) - 32'h0000_0001)
		else $error("Sleep entered before the idle delay ran out.");
	AST_WAKE: assert property (@(posedge mclk_i) disable iff (!resetn_i)
		activity_i || wr_en_i || rd_en_i |=> !sleep_o)
		else $error("Sleep held through activity.");
endmodule : brdcb_bank

// ### src/brdcb_pkg.sv
package brdcb_pkg;
	// -----------------------------------------------------------------
	// Register map
	// -----------------------------------------------------------------
	localparam logic [7:0] ADDR_PULSES_NODE = 8'h1F;
	localparam logic [7:0] ADDR_LIMIT_P1 = 8'h20;
	localparam logic [7:0] ADDR_LIMIT_P2 = 8'h21;
	localparam logic [7:0] ADDR_RECORD = 8'h22;
	localparam logic [7:0] ADDR_FREQ_WIN = 8'h23;
	localparam logic [7:0] ADDR_SAT_FREQ = 8'h24;
	localparam logic [7:0] ADDR_VOLT_SLEEP = 8'h25;
	localparam logic [7:0] ADDR_DECOUPLE = 8'h26;
	localparam logic [7:0] REG_RESET = 8'h00;
	localparam logic [7:0] LIMIT_P1_MASK = 8'hBF;
	localparam int SLEEP_ALLOW_BIT = 5;
	// -----------------------------------------------------------------
	// Scaling constants
	// -----------------------------------------------------------------
	localparam logic [9:0] LIMIT_STEP_MA = 10'h007;
	localparam logic [9:0] LIMIT_BASE_MA = 10'h032;
	localparam logic [7:0] FREQ_START_STEP_US = 8'h64;
	// Overvoltage thresholds in tenths of a volt.
	localparam logic [8:0] OV_TH_0 = 9'h07B;
	localparam logic [8:0] OV_TH_1 = 9'h0B1;
	localparam logic [8:0] OV_TH_2 = 9'h0E4;
	localparam logic [8:0] OV_TH_3 = 9'h11B;
	// Sleep entry delays in milliseconds and cycles at 50 MHz.
	localparam int CLK_KHZ = 50000;
	localparam int SLEEP_MS_0 = 250;
	localparam int SLEEP_MS_1 = 500;
	localparam int SLEEP_MS_2 = 1000;
	localparam int SLEEP_MS_3 = 4000;
	localparam int SLEEP_CYC_0 = SLEEP_MS_0 * CLK_KHZ;
	localparam int SLEEP_CYC_1 = SLEEP_MS_1 * CLK_KHZ;
	localparam int SLEEP_CYC_2 = SLEEP_MS_2 * CLK_KHZ;
	localparam int SLEEP_CYC_3 = SLEEP_MS_3 * CLK_KHZ;
endpackage : brdcb_pkg

// ### test/brdcb_host.sv
`timescale 1ns/1ps
module brdcb_host (
	// Clock.
	input wire logic mclk_i,
	// Register port towards the bank.
	output logic wr_en_o,
	output logic rd_en_o,
	output logic [7:0] addr_o,
	output logic [7:0] wdata_o,
	input wire logic [7:0] rdata_i,
	input wire logic rvalid_i
);
	// The bus is idle from time zero.
	initial begin
		wr_en_o = 1'b0;
		rd_en_o = 1'b0;
		addr_o = 8'h00;
		wdata_o = 8'h00;
	end
	// One write; released lines carry the inverse so stale values never look valid.
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge mclk_i);
		wr_en_o <= 1'b1;
		addr_o <= a;
		wdata_o <= d;
		@(posedge mclk_i);
		wr_en_o <= 1'b0;
		addr_o <= ~a;
		wdata_o <= ~d;
	endtask : wr
	// One read; the answer is taken while the one-cycle valid pulse stands.
	task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic v);
		@(posedge mclk_i);
		rd_en_o <= 1'b1;
		addr_o <= a;
		@(posedge mclk_i);
		rd_en_o <= 1'b0;
		addr_o <= ~a;
		#1;
		v = rvalid_i;
		d = rdata_i;
	endtask : rd
endmodule : brdcb_host

// ### test/tb_top.sv
`timescale 1ns/1ps
module tb_top
	import brdcb_pkg::*;
;
	// Register walk row: address, written byte, expected read-back.
	typedef struct packed {logic [7:0] a; logic [7:0] w; logic [7:0] r;} brdcb_row_t;
	localparam brdcb_row_t ROWS [9] = '{{ADDR_PULSES_NODE, 8'hA0, 8'hA0},
		{ADDR_LIMIT_P1, 8'hFF, 8'hBF}, {ADDR_LIMIT_P2, 8'h85, 8'h85},
		{ADDR_RECORD, 8'hF0, 8'hF0}, {ADDR_FREQ_WIN, 8'h3A, 8'h3A},
		{ADDR_SAT_FREQ, 8'h67, 8'h67}, {ADDR_VOLT_SLEEP, 8'hF9, 8'hF9},
		{ADDR_DECOUPLE, 8'h20, 8'h20}, {8'h30, 8'hFF, 8'h00}};
	localparam int SLP [4] = '{10, 20, 40, 80};
	localparam logic [8:0] OVT [4] = '{9'h07B, 9'h0B1, 9'h0E4, 9'h11B};
	logic mclk = 1'b0, resetn = 1'b0, activity = 1'b0, fvalid = 1'b0, v;
	logic wr_en, rd_en, rvalid, fonly, lim_on, fon, ferr_flag, sat, nl1, nl2, sleep;
	logic [7:0] addr, wdata, rdata, ferr = 8'h00, d;
	logic [3:0] decay = 4'h0, flen, vlim;
	logic [2:0] node, lpf;
	logic [4:0] pcnt, rec1, rec2;
	logic [9:0] lim1, lim2;
	logic [10:0] fstart;
	logic [8:0] ov;
	int failures = 0, n_compared = 0;
	// Clock at 50 MHz.
	always #10 mclk = ~mclk;
	brdcb_host i_brdcb_host (.mclk_i(mclk), .wr_en_o(wr_en), .rd_en_o(rd_en), .addr_o(addr),
		.wdata_o(wdata), .rdata_i(rdata), .rvalid_i(rvalid));
	brdcb_bank #(.SLEEP_CYC_P0(10), .SLEEP_CYC_P1(20), .SLEEP_CYC_P2(40), .SLEEP_CYC_P3(80))
	i_brdcb_bank (.mclk_i(mclk), .resetn_i(resetn), .wr_en_i(wr_en), .rd_en_i(rd_en),
		.addr_i(addr), .wdata_i(wdata), .rdata_o(rdata), .rvalid_o(rvalid),
		.activity_i(activity), .freq_err_us_i(ferr), .freq_err_valid_i(fvalid),
		.decay_level_i(decay), .node_address_o(node), .second_preset_pulse_count_o(pcnt),
		.second_preset_first_only_o(fonly), .drive_limit_on_o(lim_on),
		.first_preset_drive_limit_ma_o(lim1), .second_preset_drive_limit_ma_o(lim2),
		.lowpass_cutoff_khz_o(lpf), .first_preset_record_units_o(rec1),
		.second_preset_record_units_o(rec2), .freq_check_on_o(fon),
		.freq_check_window_len_o(flen), .freq_check_start_us_o(fstart),
		.freq_check_error_o(ferr_flag), .saturation_hit_o(sat),
		.first_preset_nonlinear_o(nl1), .second_preset_nonlinear_o(nl2),
		.overvoltage_th_dv_o(ov), .voltage_check_limit_o(vlim), .sleep_o(sleep));
	// Compares one value and reports a mismatch at once.
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			failures++;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : chk
	// Lets decoded outputs follow the last register change.
	task automatic settle(input int n);
		repeat (n) @(posedge mclk);
		#1;
	endtask : settle
	// Presents one timing-error measurement and checks the flag.
	task automatic fm(input logic [7:0] e, input logic exp);
		@(posedge mclk);
		ferr <= e;
		fvalid <= 1'b1;
		@(posedge mclk);
		fvalid <= 1'b0;
		settle(2);
		chk(ferr_flag, exp);
	endtask : fm
	// Prints the counts and the verdict, then ends the run.
	task automatic end_sim();
		$display("Compared %0d, failures %0d", n_compared, failures);
		if (failures == 0 && n_compared > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : end_sim
	// ----------------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------------
	initial begin
		repeat (12) @(posedge mclk);
		resetn <= 1'b1;
		foreach (ROWS[i]) begin
			i_brdcb_host.rd(ROWS[i].a, d, v);
			chk({v, d}, {1'b1, 8'h00});
		end
		chk({lim1, lpf, fonly}, {10'h032, 3'h1, 1'b1});
		foreach (ROWS[i]) begin
			i_brdcb_host.wr(ROWS[i].a, ROWS[i].w);
			i_brdcb_host.rd(ROWS[i].a, d, v);
			chk({v, d}, {1'b1, ROWS[i].r});
		end
		settle(2);
		chk({node, pcnt, fonly}, {3'h5, 5'h00, 1'b1});
		chk({lim_on, lim1, lim2}, {1'b0, 10'h1EB, 10'h055});
		chk({lpf, rec1, rec2}, {3'h3, 5'h10, 5'h01});
		chk({fon, flen, fstart}, {1'b1, 4'h3, 11'h3E8});
		chk({nl1, nl2, vlim, ov}, {1'b1, 1'b1, 4'h2, 9'h11B});
		@(posedge mclk);
		decay <= 4'h3;
		settle(3);
		chk(sat, 1'b0);
		@(posedge mclk);
		decay <= 4'h4;
		settle(3);
		chk(sat, 1'b1);
		fm(8'h04, 1'b0);
		fm(8'h05, 1'b1);
		i_brdcb_host.wr(ADDR_FREQ_WIN, 8'h0A);
		settle(3);
		chk({fon, ferr_flag}, 2'b00);
		i_brdcb_host.wr(ADDR_PULSES_NODE, 8'h1F);
		i_brdcb_host.wr(ADDR_LIMIT_P1, 8'h00);
		settle(3);
		chk({node, pcnt, fonly, lim_on}, {3'h0, 5'h1F, 1'b0, 1'b1});
		for (int k = 0; k < 4; k++) begin
			i_brdcb_host.wr(ADDR_VOLT_SLEEP, {1'b0, k[1:0], k[1:0], 3'h0});
			settle(2);
			chk({nl2, ov}, {1'b0, OVT[k]});
			settle(SLP[k] / 2);
			chk(sleep, 1'b0);
			settle(SLP[k] / 2 + 6);
			chk(sleep, 1'b1);
		end
		@(posedge mclk);
		activity <= 1'b1;
		@(posedge mclk);
		activity <= 1'b0;
		settle(2);
		chk(sleep, 1'b0);
		i_brdcb_host.wr(ADDR_DECOUPLE, 8'h00);
		settle(200);
		chk(sleep, 1'b0);
		@(posedge mclk);
		resetn <= 1'b0;
		repeat (2) @(posedge mclk);
		resetn <= 1'b1;
		i_brdcb_host.rd(ADDR_LIMIT_P2, d, v);
		chk({v, d, lim2, lpf}, {1'b1, 8'h00, 10'h032, 3'h1});
		end_sim();
	end
	// Watchdog against a hang.
	initial begin
		repeat (5000) @(posedge mclk);
		failures++;
		end_sim();
	end
endmodule : tb_top
